// [hw/tdd_port_pkg.sv]
// Purpose: Shared constants and types for the duplex converter port
// Assumes: 100 MHz system clock
// Notes: Mode encoding shared by the port and its mode decoder
package tdd_port_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int DAC_WIDTH = 7;
  localparam int ADC_WIDTH = 5;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [6:0] DAC_RESET = 7'h00;
  localparam logic [4:0] ADC_RESET = 5'h00;
  localparam logic [6:0] DAC_POS_FULL = 7'h3f;
  localparam logic [6:0] DAC_NEG_FULL = 7'h40;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_TIME_NS = 2400;
  localparam int WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] WAKE_COUNT = 9'(WAKE_CYCLES);

  // ****************************************************************
  // Modes, Gray coded along shutdown, receive, transmit
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_SHUTDOWN = 2'b00,
    MODE_RECEIVE = 2'b01,
    MODE_TRANSMIT = 2'b11
  } mode_e;

  // Decode the enable pair into a mode
  function automatic mode_e decode_mode(input logic rx, input logic tx);
    if (rx && !tx) begin
      return MODE_RECEIVE;
    end else if (tx && !rx) begin
      return MODE_TRANSMIT;
    end
    return MODE_SHUTDOWN;
  endfunction

endpackage

// [hw/mode_if.sv]
// Purpose: Carries mode and readiness between decoder and port
// Assumes: Single clock domain
// Notes: Decoder drives, port reads
`timescale 1ns/1ps
interface mode_if;
  import tdd_port_pkg::*;
  mode_e mode;
  logic ready;
  modport source (output mode, output ready);
  modport sink (input mode, input ready);
endinterface

// [hw/mode_decoder.sv]
// Purpose: Synchronises the enables and tracks mode and wake-up
// Assumes: Enables arrive asynchronously from the controller
// Notes: Three flops per enable; change accepted when last two agree
`timescale 1ns/1ps
module mode_decoder
  import tdd_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic receive_enable_in,
  input wire logic transmit_enable_in,
  mode_if.source mif
);

  logic [2:0] rx_sync;
  logic [2:0] tx_sync;
  logic rx_stable;
  logic tx_stable;
  mode_e mode;
  logic [8:0] wake_cnt;
  logic [2:0] next_rx_sync;
  logic [2:0] next_tx_sync;
  logic next_rx_stable;
  logic next_tx_stable;
  mode_e next_mode;
  logic [8:0] next_wake_cnt;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_rx_sync = {rx_sync[1:0], receive_enable_in};
    next_tx_sync = {tx_sync[1:0], transmit_enable_in};
    next_rx_stable = (rx_sync[1] == rx_sync[2]) ? rx_sync[2] : rx_stable;
    next_tx_stable = (tx_sync[1] == tx_sync[2]) ? tx_sync[2] : tx_stable;
    next_mode = decode_mode(rx_stable, tx_stable);
    next_wake_cnt = wake_cnt;
    case (next_mode)
      MODE_SHUTDOWN: begin
        next_wake_cnt = WAKE_COUNT;
      end
      default: begin
        if (next_mode != mode) begin
          next_wake_cnt = WAKE_COUNT;
        end else if (wake_cnt != 9'h000) begin
          next_wake_cnt = wake_cnt - 9'h001;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync <= 3'h0;
      tx_sync <= 3'h0;
      rx_stable <= 1'b0;
      tx_stable <= 1'b0;
      mode <= MODE_SHUTDOWN;
      wake_cnt <= WAKE_COUNT;
    end else begin
      rx_sync <= next_rx_sync;
      tx_sync <= next_tx_sync;
      rx_stable <= next_rx_stable;
      tx_stable <= next_tx_stable;
      mode <= next_mode;
      wake_cnt <= next_wake_cnt;
    end
  end

  assign mif.mode = mode;
  assign mif.ready = (mode != MODE_SHUTDOWN) && (wake_cnt == 9'h000);

endmodule // mode_decoder

// [hw/tdd_adc_dac_mode_port.sv]
// Purpose: Digital port of a duplex converter with shared data pins
// Assumes: Converter clock, enables and data pins come from a controller
// Notes: Converter clock is sampled on the system clock
`timescale 1ns/1ps
module tdd_adc_dac_mode_port
  import tdd_port_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic conv_clk_in,
  input wire logic receive_enable_in,
  input wire logic transmit_enable_in,
  input wire logic dac_data_bit_top,
  input wire logic dac_data_bit_second,
  input wire logic [4:0] shared_data_pins_in,
  output logic [4:0] shared_data_pins_out,
  output logic [4:0] shared_data_pins_oe,
  input wire logic [4:0] adc_sample_in,
  output logic [6:0] dac_code_out,
  output logic dac_active,
  output logic adc_active,
  output logic analog_pair_is_output,
  output logic converter_ready
);

  mode_if mif ();

  // ****************************************************************
  // Mode decoding
  // ****************************************************************
  mode_decoder u_mode (
    .clk(clk),
    .resetn(resetn),
    .receive_enable_in(receive_enable_in),
    .transmit_enable_in(transmit_enable_in),
    .mif(mif)
  );

  logic [2:0] cclk_sync;
  logic cclk_level;
  logic [2:0] top_sync;
  logic [2:0] sec_sync;
  logic [14:0] low_sync;
  logic [4:0] adc_samp_sync;
  logic [6:0] dac_master;
  logic [6:0] dac_slave;
  logic [4:0] adc_held;
  logic [4:0] adc_out;
  logic [4:0] pin_oe;
  logic dac_on;
  logic adc_on;
  logic ana_out;
  logic ready;
  logic [2:0] next_cclk_sync;
  logic next_cclk_level;
  logic [2:0] next_top_sync;
  logic [2:0] next_sec_sync;
  logic [14:0] next_low_sync;
  logic [6:0] next_dac_master;
  logic [6:0] next_dac_slave;
  logic [4:0] next_adc_held;
  logic [4:0] next_adc_out;
  logic [4:0] next_pin_oe;
  logic next_dac_on;
  logic next_adc_on;
  logic next_ana_out;
  logic next_ready;
  logic fall;
  logic rise;
  logic [6:0] pin_word;
  logic tx_mode;
  logic rx_mode;
  logic [6:0] pin_mid;
  logic [6:0] pin_last;
  logic [6:0] pin_diff;
  logic [6:0] pin_level;
  logic [6:0] next_pin_level;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  always_comb begin
    next_cclk_sync = {cclk_sync[1:0], conv_clk_in};
    next_cclk_level = (cclk_sync[1] == cclk_sync[2]) ? cclk_sync[2] : cclk_level;
    fall = cclk_level && !next_cclk_level;
    rise = !cclk_level && next_cclk_level;
    next_top_sync = {top_sync[1:0], dac_data_bit_top};
    next_sec_sync = {sec_sync[1:0], dac_data_bit_second};
    next_low_sync = {low_sync[9:0], shared_data_pins_in};
    tx_mode = (mif.mode == MODE_TRANSMIT);
    rx_mode = (mif.mode == MODE_RECEIVE);
    // Top pin is MSB, lowest shared pin is LSB
    pin_mid = {top_sync[1], sec_sync[1], low_sync[9:5]};
    pin_last = {top_sync[2], sec_sync[2], low_sync[14:10]};
    // A data bit only moves once its last two stages agree
    pin_diff = pin_mid ^ pin_last;
    next_pin_level = (pin_last & ~pin_diff) | (pin_level & pin_diff);
    pin_word = pin_level;
  end

  // ****************************************************************
  // Converter data paths
  // ****************************************************************
  always_comb begin
    next_dac_master = dac_master;
    next_dac_slave = dac_slave;
    next_adc_held = adc_held;
    next_adc_out = adc_out;
    case (mif.mode)
      MODE_TRANSMIT: begin
        next_adc_out = ADC_RESET;
        if (fall) begin
          next_dac_master = pin_word;
        end
        if (rise) begin
          next_dac_slave = dac_master;
        end
      end
      MODE_RECEIVE: begin
        if (fall) begin
          next_adc_held = adc_samp_sync;
        end
        if (rise) begin
          next_adc_out = adc_held;
        end
      end
      default: begin
        next_adc_out = ADC_RESET;
      end
    endcase
  end

  // ****************************************************************
  // Mode flags
  // ****************************************************************
  // Flags and pin enables follow the decoded mode
  always_comb begin
    next_dac_on = tx_mode;
    next_adc_on = rx_mode;
    next_ana_out = tx_mode;
    next_pin_oe = rx_mode ? 5'h1f : 5'h00;
    next_ready = mif.ready;
  end

  // ****************************************************************
  // Synchroniser registers
  // ****************************************************************
  // Three stages per clock and DAC data pin, one for the ADC sample, plus the settled levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cclk_sync <= 3'h0;
      cclk_level <= 1'b0;
      top_sync <= 3'h0;
      sec_sync <= 3'h0;
      low_sync <= 15'h0000;
      pin_level <= DAC_RESET;
      adc_samp_sync <= ADC_RESET;
    end else begin
      cclk_sync <= next_cclk_sync;
      cclk_level <= next_cclk_level;
      top_sync <= next_top_sync;
      sec_sync <= next_sec_sync;
      low_sync <= next_low_sync;
      pin_level <= next_pin_level;
      adc_samp_sync <= adc_sample_in;
    end
  end

  // ****************************************************************
  // Converter data registers
  // ****************************************************************
  // Master, slave and ADC output stages
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dac_master <= DAC_RESET;
      dac_slave <= DAC_RESET;
      adc_held <= ADC_RESET;
      adc_out <= ADC_RESET;
    end else begin
      dac_master <= next_dac_master;
      dac_slave <= next_dac_slave;
      adc_held <= next_adc_held;
      adc_out <= next_adc_out;
    end
  end

  // ****************************************************************
  // Status registers
  // ****************************************************************
  // Mode flags, pin enables and readiness
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_oe <= 5'h00;
      dac_on <= 1'b0;
      adc_on <= 1'b0;
      ana_out <= 1'b0;
      ready <= 1'b0;
    end else begin
      pin_oe <= next_pin_oe;
      dac_on <= next_dac_on;
      adc_on <= next_adc_on;
      ana_out <= next_ana_out;
      ready <= next_ready;
    end
  end

  // Outputs straight from flops
  assign shared_data_pins_out = adc_out;
  assign shared_data_pins_oe = pin_oe;
  assign dac_code_out = dac_slave;
  assign dac_active = dac_on;
  assign adc_active = adc_on;
  assign analog_pair_is_output = ana_out;
  assign converter_ready = ready;

endmodule // tdd_adc_dac_mode_port

// [tb/tdd_adc_dac_mode_port_sva.sv]
// Purpose: Port checks for the duplex converter port
// Assumes: Sees top ports only
// Notes: Bound below
`timescale 1ns/1ps
module tdd_port_sva (
  input logic clk,
  input logic resetn,
  input logic conv_clk_in,
  input logic receive_enable_in,
  input logic transmit_enable_in,
  input logic dac_data_bit_top,
  input logic dac_data_bit_second,
  input logic [4:0] shared_data_pins_in,
  input logic [4:0] shared_data_pins_out,
  input logic [4:0] shared_data_pins_oe,
  input logic [4:0] adc_sample_in,
  input logic [6:0] dac_code_out,
  input logic dac_active,
  input logic adc_active,
  input logic analog_pair_is_output,
  input logic converter_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ****************************************************************
  // Held enable patterns
  // ****************************************************************
  sequence s_rx;
    (receive_enable_in && !transmit_enable_in) [*8];
  endsequence
  sequence s_tx;
    (transmit_enable_in && !receive_enable_in) [*8];
  endsequence
  sequence s_off;
    (receive_enable_in == transmit_enable_in) [*8];
  endsequence
  property p_rx; s_rx |=> adc_active && !dac_active; endproperty
  property p_tx; s_tx |=> dac_active && !adc_active; endproperty
  property p_off; s_off |=> !adc_active && !dac_active; endproperty
  property p_excl; !(adc_active && dac_active); endproperty
  property p_oe; shared_data_pins_oe != 5'h00 |-> adc_active; endproperty
  property p_out; !adc_active |-> shared_data_pins_out == 5'h00; endproperty
  property p_pair; analog_pair_is_output == dac_active; endproperty
  property p_ready; converter_ready |-> dac_active || adc_active; endproperty
  property p_wake; $rose(dac_active) |-> !converter_ready [*8]; endproperty
  property p_hold; !dac_active && $past(!dac_active) |-> $stable(dac_code_out); endproperty
  a_rx: assert property (p_rx) else $error("receive not entered");
  a_tx: assert property (p_tx) else $error("transmit not entered");
  a_off: assert property (p_off) else $error("shutdown not entered");
  a_excl: assert property (p_excl) else $error("both converters on");
  a_oe: assert property (p_oe) else $error("pins driven outside receive");
  a_out: assert property (p_out) else $error("output outside receive");
  a_pair: assert property (p_pair) else $error("analog pair direction");
  a_ready: assert property (p_ready) else $error("ready in shutdown");
  a_wake: assert property (p_wake) else $error("ready too early");
  a_hold: assert property (p_hold) else $error("code moved outside transmit");
endmodule // tdd_port_sva
bind tdd_adc_dac_mode_port tdd_port_sva i_sva (.clk, .resetn, .conv_clk_in, .receive_enable_in,
  .transmit_enable_in, .dac_data_bit_top, .dac_data_bit_second, .shared_data_pins_in,
  .shared_data_pins_out, .shared_data_pins_oe, .adc_sample_in, .dac_code_out, .dac_active,
  .adc_active, .analog_pair_is_output, .converter_ready);

// [tb/ctrl_model.sv]
// Purpose: Baseband controller stand-in
// Assumes: Moves on the falling system clock edge
// Notes: Released pins show the last word, inverted while receive is requested
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk,
  input wire logic [4:0] dut_out,
  input wire logic [4:0] dut_oe,
  output logic conv_clk,
  output logic rx_en,
  output logic tx_en,
  output logic [6:0] word,
  output logic [4:0] pins,
  output logic [4:0] sample
);
  logic drive = 1'b1;
  initial begin
    conv_clk = 1'b1;
    rx_en = 1'b0;
    tx_en = 1'b0;
    word = 7'h00;
    sample = 5'h00;
  end
  // Shared pin resolution
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pins[i] = dut_oe[i] ? dut_out[i] : (drive ? word[i] : ~word[i]);
    end
  end
  task automatic set_mode(input logic rx, input logic tx);
    @(negedge clk);
    rx_en = rx;
    tx_en = tx;
    drive = !(rx && !tx);
    if (rx == tx) begin
      word = 7'h00;
    end
    repeat (12) @(negedge clk);
  endtask
  task automatic put(input logic [6:0] w, input logic [4:0] s);
    @(negedge clk);
    word = w;
    sample = s;
  endtask
  // Clock low and high for eight periods each
  task automatic conv_fall;
    @(negedge clk);
    conv_clk = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic conv_rise;
    conv_clk = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule // ctrl_model

// [tb/test_tdd_adc_dac_mode_port.sv]
// Purpose: Self-checking bench for the converter port
// Assumes: Controller model drives all pins
// Notes: Fixed waits follow the sync latency
`timescale 1ns/1ps
module test_tdd_adc_dac_mode_port;
  import tdd_port_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cclk, rx, tx, act_d, act_a, pair_o, rdy;
  logic [6:0] word, code;
  logic [4:0] pins, p_out, p_oe, smp;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  ctrl_model i_ctrl (.clk(clk), .dut_out(p_out), .dut_oe(p_oe), .conv_clk(cclk), .rx_en(rx),
    .tx_en(tx), .word(word), .pins(pins), .sample(smp));
  tdd_adc_dac_mode_port i_dut (.clk(clk), .resetn(resetn), .conv_clk_in(cclk),
    .receive_enable_in(rx), .transmit_enable_in(tx), .dac_data_bit_top(word[6]),
    .dac_data_bit_second(word[5]), .shared_data_pins_in(pins), .shared_data_pins_out(p_out),
    .shared_data_pins_oe(p_oe), .adc_sample_in(smp), .dac_code_out(code), .dac_active(act_d),
    .adc_active(act_a), .analog_pair_is_output(pair_o), .converter_ready(rdy));
  task automatic check(input logic [6:0] got, input logic [6:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Timeout
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task automatic t_modes;
    logic [1:0] m;
    for (int k = 0; k < 4; k++) begin
      m = 2'(k);
      i_ctrl.set_mode(m[1], m[0]);
      check({4'h0, act_a, act_d, pair_o}, {4'h0, m == 2'b10, m == 2'b01, m == 2'b01});
      check({2'h0, p_oe}, {2'h0, {5{m == 2'b10}}});
    end
    $display("modes done");
  endtask
  task automatic t_tx;
    logic [6:0] w[3] = '{DAC_POS_FULL, DAC_NEG_FULL, 7'h55};
    logic [6:0] prev = DAC_RESET;
    int n = 12;
    i_ctrl.set_mode(1'b0, 1'b1);
    while (rdy !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(7'(n >= WAKE_CYCLES && n <= WAKE_CYCLES + 12), 7'h01);
    foreach (w[k]) begin
      i_ctrl.put(w[k], 5'h00);
      i_ctrl.conv_fall();
      check(code, prev);
      i_ctrl.conv_rise();
      check(code, w[k]);
      prev = w[k];
    end
    $display("transmit done");
  endtask
  task automatic t_rx;
    logic [4:0] s[2] = '{5'h11, 5'h0e};
    logic [4:0] prev = ADC_RESET;
    logic [6:0] hold;
    i_ctrl.set_mode(1'b1, 1'b0);
    hold = code;
    foreach (s[k]) begin
      i_ctrl.put({k[0], ~k[0], 5'h00}, s[k]);
      i_ctrl.conv_fall();
      check({2'h0, p_out}, {2'h0, prev});
      i_ctrl.conv_rise();
      check({2'h0, p_out}, {2'h0, s[k]});
      prev = s[k];
    end
    check(code, hold);
    // Straight from receive to transmit: result pins must clear
    i_ctrl.set_mode(1'b0, 1'b1);
    check({2'h0, p_out}, {2'h0, ADC_RESET});
    check({2'h0, p_oe}, 7'h00);
    $display("receive done");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    t_modes();
    t_tx();
    t_rx();
    i_ctrl.set_mode(1'b1, 1'b1);
    end_of_test();
  end
endmodule // test_tdd_adc_dac_mode_port
